// File: core/ocp_pickup.sv
// Three-phase overcurrent pick-up comparator, top level
//
// Notes on behaviour
// - Selector 1 RMS, 2 true RMS, 3 peak-to-peak; RMS after reset.
// - Peak-to-peak is built here from raw samples, not processed values.
// - True RMS input covers harmonics up to the 32nd.
// - Pre-fault value is 20 ms average ending 20 ms before start/trip.
// - All phases share one threshold; any phase over it picks up.
// - Release only below 97 % of threshold; fixed hysteresis.
// - Threshold in 0.01 nominal steps, default 1.20 nominal.
// - Start only while picked up and not blocked.
// - With forcing enabled, forced status code 0..17 drives outputs.
// - Stage code: 0 normal, 1 start, 2 trip, 3 blocked.
// - Phase code 0..14 for single, pair and three-phase start/trip.
// - Expected time, 5 ms steps; inverse mode follows current changes.
// - Remaining time to trip counts down in 5 ms steps, to 1800 s.
// - Ratio of highest phase to threshold, 0.01 resolution.
// - Remote threshold writes only when permission equals 2.
// - Permission, forcing and selector are static, outside groups.
// - Block present at pick-up gives blocked and no further processing.
`timescale 1ns/1ps
`default_nettype none
`include "ocp_regs.svh"

module ocp_pickup #(
  parameter int MW = `OCP_MAG_W,
  parameter int TW = `OCP_TIME_W
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_meas_valid,
  input  wire logic [MW-1:0]          i_phase_a_rms,
  input  wire logic [MW-1:0]          i_phase_b_rms,
  input  wire logic [MW-1:0]          i_phase_c_rms,
  input  wire logic [MW-1:0]          i_phase_a_true_rms,
  input  wire logic [MW-1:0]          i_phase_b_true_rms,
  input  wire logic [MW-1:0]          i_phase_c_true_rms,
  input  wire logic                   i_sample_valid,
  input  wire logic [3*MW-1:0]        i_samples,
  input  wire logic [1:0]             i_mag_select,
  input  wire logic [`OCP_THR_W-1:0]  i_thr_value,
  input  wire logic                   i_thr_wr_local,
  input  wire logic                   i_thr_wr_remote,
  input  wire logic [1:0]             i_remote_perm,
  input  wire logic                   i_block,
  input  wire logic                   i_force_en,
  input  wire logic [4:0]             i_force_code,
  input  wire logic                   i_inverse_mode,
  input  wire logic [TW-1:0]          i_op_delay,
  input  wire logic [TW-1:0]          i_idmt_time,
  output logic                        o_start,
  output logic                        o_trip,
  output logic                        o_blocked,
  output logic [1:0]                  o_stage_code,
  output logic [3:0]                  o_phase_code,
  output logic [`OCP_THR_W-1:0]       o_threshold,
  output logic [MW-1:0]               o_measured_magnitude,
  output logic [MW-1:0]               o_prefault,
  output logic [TW-1:0]               o_expected_time,
  output logic [TW-1:0]               o_remaining_time,
  output logic [`OCP_RATIO_W-1:0]     o_ratio,
  output logic                        o_ratio_valid
);

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------
  function automatic logic [3:0] phase_code(input logic [2:0] m,
                                            input logic       trip);
    logic [3:0] c;
    unique case (m)
      3'b001:  c = 4'h1;
      3'b010:  c = 4'h2;
      3'b100:  c = 4'h3;
      3'b011:  c = 4'h7;
      3'b110:  c = 4'h8;
      3'b101:  c = 4'h9;
      3'b111:  c = 4'hA;
      default: c = 4'h0;
    endcase
    if (trip && c != 4'h0)
      c = (c < 4'h4) ? c + 4'h3 : c + 4'h4;
    return c;
  endfunction

  function automatic logic [22:0] pct(input logic [MW-1:0] v,
                                      input logic [6:0]    p);
    return 23'(v) * 23'(p);
  endfunction

  // ------------------------------------------------------------------
  // Magnitude selection and peak-to-peak from samples
  // ------------------------------------------------------------------
  logic [MW-1:0] pmax_r [3], pmax_nxt [3];
  logic [MW-1:0] pmin_r [3], pmin_nxt [3];
  logic [MW-1:0] phase_a_peak_to_peak, phase_b_peak_to_peak;
  logic [MW-1:0] phase_c_peak_to_peak;
  logic [MW-1:0] pp [3];
  logic [MW-1:0] mag [3];
  logic [MW-1:0] max_mag;
  logic [MW:0]   diff;
  logic [MW-1:0] smp;
  ocp_pkg::ocp_mag_sel_type sel;

  always_comb begin
    diff = '0;
    smp  = '0;
    for (int p = 0; p < 3; p++) begin
      smp = i_samples[p*MW +: MW];
      diff = {pmax_r[p][MW-1], pmax_r[p]} - {pmin_r[p][MW-1], pmin_r[p]};
      pp[p] = diff[MW] ? {MW{1'b1}} : diff[MW-1:0];
      pmax_nxt[p] = pmax_r[p];
      pmin_nxt[p] = pmin_r[p];
      if (i_meas_valid) begin
        // Window restarts at each update
        pmax_nxt[p] = smp;
        pmin_nxt[p] = smp;
      end else if (i_sample_valid) begin
        if ($signed(smp) > $signed(pmax_r[p])) pmax_nxt[p] = smp;
        if ($signed(smp) < $signed(pmin_r[p])) pmin_nxt[p] = smp;
      end
    end
  end

  assign phase_a_peak_to_peak = pp[0];
  assign phase_b_peak_to_peak = pp[1];
  assign phase_c_peak_to_peak = pp[2];

  // Illegal selector code falls back to RMS
  assign sel = (i_mag_select == 2'h2) ? ocp_pkg::OCP_SEL_TRUE_RMS_MODE :
               (i_mag_select == 2'h3) ? ocp_pkg::OCP_SEL_PP :
                                        ocp_pkg::OCP_SEL_RMS;

  always_comb begin
    unique case (sel)
      ocp_pkg::OCP_SEL_TRUE_RMS_MODE: begin
        mag[0] = i_phase_a_true_rms;
        mag[1] = i_phase_b_true_rms;
        mag[2] = i_phase_c_true_rms;
      end
      ocp_pkg::OCP_SEL_PP: begin
        mag[0] = phase_a_peak_to_peak;
        mag[1] = phase_b_peak_to_peak;
        mag[2] = phase_c_peak_to_peak;
      end
      default: begin
        mag[0] = i_phase_a_rms;
        mag[1] = i_phase_b_rms;
        mag[2] = i_phase_c_rms;
      end
    endcase
    max_mag = mag[0];
    for (int p = 1; p < 3; p++)
      if (mag[p] > max_mag) max_mag = mag[p];
  end

  // ------------------------------------------------------------------
  // Threshold, comparison and stage sequence
  // ------------------------------------------------------------------
  logic [`OCP_THR_W-1:0] thr_nxt;
  logic [2:0]            pu_r, pu_nxt;
  logic [MW-1:0]         hist_r [`OCP_HIST_DEPTH];
  logic [MW-1:0]         hist_nxt [`OCP_HIST_DEPTH];
  logic [MW+2:0]         pf_sum;
  logic [MW-1:0]         pf_nxt, meas_nxt;
  logic [TW-1:0]         elapsed_r, elapsed_nxt, exp_nxt, rem_nxt;
  logic                  tick_d_r;
  ocp_pkg::ocp_stage_type st_r, st_nxt;

  always_comb begin
    thr_nxt = o_threshold;
    if (i_thr_wr_local ||
        (i_thr_wr_remote && i_remote_perm == `OCP_PERM_ALLOWED))
      thr_nxt = i_thr_value;
  end

  always_comb begin
    pu_nxt      = pu_r;
    st_nxt      = st_r;
    elapsed_nxt = elapsed_r;
    meas_nxt    = o_measured_magnitude;
    exp_nxt     = o_expected_time;
    pf_nxt      = o_prefault;
    hist_nxt    = hist_r;
    pf_sum      = '0;
    for (int t = `OCP_PREFAULT_TAPS; t < `OCP_HIST_DEPTH; t++)
      pf_sum = pf_sum + (MW+3)'(hist_r[t]);
    if (i_meas_valid) begin
      for (int p = 0; p < 3; p++) begin
        if (!pu_r[p])
          pu_nxt[p] = mag[p] > MW'(o_threshold);
        else
          pu_nxt[p] = !(pct(mag[p], `OCP_FULL_PCT) <
                        pct(MW'(o_threshold), `OCP_RESET_PCT));
      end
      meas_nxt = max_mag;
      hist_nxt[0] = max_mag;
      for (int t = 1; t < `OCP_HIST_DEPTH; t++)
        hist_nxt[t] = hist_r[t-1];
      // Inverse time follows the latest curve result at each update
      exp_nxt = i_inverse_mode ? i_idmt_time : i_op_delay;
      unique case (st_r)
        ocp_pkg::OCP_ST_NORMAL:
          if (pu_nxt != 3'h0) begin
            elapsed_nxt = '0;
            st_nxt = i_block ? ocp_pkg::OCP_ST_BLOCKED
                             : ocp_pkg::OCP_ST_START;
          end
        ocp_pkg::OCP_ST_START:
          if (pu_nxt == 3'h0)
            st_nxt = ocp_pkg::OCP_ST_NORMAL;
          else if (i_block)
            st_nxt = ocp_pkg::OCP_ST_BLOCKED;
          else begin
            if (elapsed_r < `OCP_TIME_MAX)
              elapsed_nxt = elapsed_r + 1'b1;
            if (elapsed_r + 1'b1 >= exp_nxt)
              st_nxt = ocp_pkg::OCP_ST_TRIP;
          end
        ocp_pkg::OCP_ST_TRIP,
        ocp_pkg::OCP_ST_BLOCKED:
          if (pu_nxt == 3'h0)
            st_nxt = ocp_pkg::OCP_ST_NORMAL;
      endcase
      if ((st_nxt == ocp_pkg::OCP_ST_START &&
           st_r == ocp_pkg::OCP_ST_NORMAL) ||
          (st_nxt == ocp_pkg::OCP_ST_TRIP &&
           st_r != ocp_pkg::OCP_ST_TRIP))
        pf_nxt = pf_sum[MW+1:2];
    end
    rem_nxt = (st_nxt == ocp_pkg::OCP_ST_START && exp_nxt > elapsed_nxt)
              ? exp_nxt - elapsed_nxt : '0;
  end

  // ------------------------------------------------------------------
  // Output encoding, with forcing taking over the outputs
  // ------------------------------------------------------------------
  logic       start_nxt, trip_nxt, blk_nxt;
  logic [1:0] stage_nxt;
  logic [3:0] phase_nxt;

  always_comb begin
    start_nxt = st_nxt == ocp_pkg::OCP_ST_START;
    trip_nxt  = st_nxt == ocp_pkg::OCP_ST_TRIP;
    blk_nxt   = st_nxt == ocp_pkg::OCP_ST_BLOCKED;
    phase_nxt = (start_nxt || trip_nxt) ? phase_code(pu_nxt, trip_nxt)
                                        : 4'h0;
    if (i_force_en) begin
      start_nxt = i_force_code == 5'h01 ||
                  (i_force_code >= 5'h04 && i_force_code <= 5'h06) ||
                  (i_force_code >= 5'h0A && i_force_code <= 5'h0D);
      trip_nxt  = i_force_code == 5'h02 ||
                  (i_force_code >= 5'h07 && i_force_code <= 5'h09) ||
                  (i_force_code >= 5'h0E && i_force_code <= 5'h11);
      blk_nxt   = i_force_code == 5'h03;
      // Forced phase codes sit three above the reported ones
      phase_nxt = (i_force_code >= 5'h04 && i_force_code <= 5'h11)
                  ? 4'(i_force_code - 5'h03) : 4'h0;
    end
    stage_nxt = trip_nxt  ? ocp_pkg::OCP_COND_TRIP :
                start_nxt ? ocp_pkg::OCP_COND_START :
                blk_nxt   ? ocp_pkg::OCP_COND_BLOCKED :
                            ocp_pkg::OCP_COND_NORMAL;
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int p = 0; p < 3; p++) begin
        pmax_r[p] <= '0;
        pmin_r[p] <= '0;
      end
      for (int t = 0; t < `OCP_HIST_DEPTH; t++)
        hist_r[t] <= '0;
      o_threshold          <= `OCP_THR_DEFAULT;
      pu_r                 <= 3'h0;
      st_r                 <= ocp_pkg::OCP_ST_NORMAL;
      elapsed_r            <= '0;
      tick_d_r             <= 1'b0;
      o_measured_magnitude <= '0;
      o_prefault           <= '0;
      o_expected_time      <= '0;
      o_remaining_time     <= '0;
      o_start              <= 1'b0;
      o_trip               <= 1'b0;
      o_blocked            <= 1'b0;
      o_stage_code         <= 2'h0;
      o_phase_code         <= 4'h0;
    end else begin
      pmax_r               <= pmax_nxt;
      pmin_r               <= pmin_nxt;
      hist_r               <= hist_nxt;
      o_threshold          <= thr_nxt;
      pu_r                 <= pu_nxt;
      st_r                 <= st_nxt;
      elapsed_r            <= elapsed_nxt;
      tick_d_r             <= i_meas_valid;
      o_measured_magnitude <= meas_nxt;
      o_prefault           <= pf_nxt;
      o_expected_time      <= exp_nxt;
      o_remaining_time     <= rem_nxt;
      o_start              <= start_nxt;
      o_trip               <= trip_nxt;
      o_blocked            <= blk_nxt;
      o_stage_code         <= stage_nxt;
      o_phase_code         <= phase_nxt;
    end
  end

  // Ratio recomputed after each update from the new highest phase
  ocp_ratio_div u_ratio (
    .i_ref_clk (i_ref_clk),
    .i_reset_n (i_reset_n),
    .i_go      (tick_d_r),
    .i_num     (pct(o_measured_magnitude, `OCP_FULL_PCT)),
    .i_den     (o_threshold),
    .o_ratio   (o_ratio),
    .o_valid   (o_ratio_valid)
  );

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);

  sequence tick_blocked_pickup;
    i_meas_valid && st_r == ocp_pkg::OCP_ST_NORMAL && i_block &&
    pu_nxt != 3'h0 && !i_force_en;
  endsequence

  start_needs_pu_a: assert property (o_start && !i_force_en &&
    !$past(i_force_en) |->
    pu_r != 3'h0 && !o_blocked) else $error("start without pick-up");
  hold_between_a: assert property (!i_meas_valid |=> $stable(pu_r))
    else $error("pick-up moved between updates");
  hyst_keep_a: assert property (i_meas_valid && pu_r[0] &&
    pct(mag[0], `OCP_FULL_PCT) >= pct(MW'(o_threshold), `OCP_RESET_PCT)
    |=> pu_r[0]) else $error("phase released above reset level");
  pickup_set_a: assert property (i_meas_valid && mag[1] > MW'(o_threshold)
    |=> pu_r[1]) else $error("phase over threshold not picked up");
  block_first_a: assert property (tick_blocked_pickup |=>
    o_blocked && !o_start && o_stage_code == 2'h3)
    else $error("blocked pick-up not reported");
  remote_gate_a: assert property (i_thr_wr_remote && !i_thr_wr_local &&
    i_remote_perm != `OCP_PERM_ALLOWED |=> $stable(o_threshold))
    else $error("remote write taken without permission");
  force_trip_a: assert property (i_force_en && i_force_code == 5'h11
    |=> o_trip && o_stage_code == 2'h2 && o_phase_code == 4'hE)
    else $error("forced trip ABC not shown");
  phase_a_code_a: assert property (!i_force_en && st_nxt ==
    ocp_pkg::OCP_ST_START && pu_nxt == 3'b001 |=> o_phase_code == 4'h1)
    else $error("phase A start code wrong");
  remain_step_a: assert property (o_start && !i_force_en &&
    i_meas_valid && !i_inverse_mode && $stable(i_op_delay) &&
    st_nxt == ocp_pkg::OCP_ST_START && o_remaining_time > 0
    |=> o_remaining_time == $past(o_remaining_time) - 1'b1)
    else $error("remaining time not one step down");
  ratio_done_a: assert property (tick_d_r |-> ##24 o_ratio_valid)
    else $error("ratio not ready in time");

endmodule
`default_nettype wire

// File: core/ocp_pkg.sv
// Types of the overcurrent pick-up comparator
package ocp_pkg;

  typedef enum logic [1:0] {
    OCP_SEL_RMS  = 2'h1,
    OCP_SEL_TRUE_RMS_MODE = 2'h2,
    OCP_SEL_PP   = 2'h3
  } ocp_mag_sel_type;

  // Gray along normal -> start -> trip
  typedef enum logic [1:0] {
    OCP_ST_NORMAL  = 2'h0,
    OCP_ST_START   = 2'h1,
    OCP_ST_TRIP    = 2'h3,
    OCP_ST_BLOCKED = 2'h2
  } ocp_stage_type;

  // Reported overall condition codes
  typedef enum logic [1:0] {
    OCP_COND_NORMAL  = 2'h0,
    OCP_COND_START   = 2'h1,
    OCP_COND_TRIP    = 2'h2,
    OCP_COND_BLOCKED = 2'h3
  } ocp_cond_type;

endpackage

// File: core/ocp_ratio_div.sv
// Serial divider for the measured-to-threshold ratio
`timescale 1ns/1ps
`default_nettype none
`include "ocp_regs.svh"

module ocp_ratio_div #(
  parameter int NUM_W = 23,
  parameter int DEN_W = `OCP_THR_W,
  parameter int OUT_W = `OCP_RATIO_W
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_go,
  input  wire logic [NUM_W-1:0] i_num,
  input  wire logic [DEN_W-1:0] i_den,
  output logic      [OUT_W-1:0] o_ratio,
  output logic                  o_valid
);

  logic [NUM_W-1:0] quo_r, quo_nxt;
  logic [DEN_W:0]   rem_r, rem_nxt;
  logic [DEN_W-1:0] den_r, den_nxt;
  logic [4:0]       cnt_r, cnt_nxt;
  logic             busy_r, busy_nxt;
  logic [OUT_W-1:0] ratio_nxt;
  logic             valid_nxt;
  logic [DEN_W+1:0] trial;

  // One quotient bit per clock; a new request restarts the division
  always_comb begin
    quo_nxt   = quo_r;
    rem_nxt   = rem_r;
    den_nxt   = den_r;
    cnt_nxt   = cnt_r;
    busy_nxt  = busy_r;
    ratio_nxt = o_ratio;
    valid_nxt = 1'b0;
    trial     = {rem_r, quo_r[NUM_W-1]} - {2'h0, den_r};
    if (i_go) begin
      quo_nxt  = i_num;
      rem_nxt  = '0;
      den_nxt  = i_den;
      cnt_nxt  = 5'(NUM_W);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (!trial[DEN_W+1]) begin
        rem_nxt = trial[DEN_W:0];
        quo_nxt = {quo_r[NUM_W-2:0], 1'b1};
      end else begin
        rem_nxt = {rem_r[DEN_W-1:0], quo_r[NUM_W-1]};
        quo_nxt = {quo_r[NUM_W-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - 5'h01;
      if (cnt_r == 5'h01) begin
        busy_nxt  = 1'b0;
        valid_nxt = 1'b1;
        // Zero threshold cannot occur in range, but saturate anyway
        if (den_r == '0 || quo_nxt > NUM_W'(`OCP_RATIO_MAX))
          ratio_nxt = `OCP_RATIO_MAX;
        else
          ratio_nxt = quo_nxt[OUT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      quo_r   <= '0;
      rem_r   <= '0;
      den_r   <= '0;
      cnt_r   <= 5'h00;
      busy_r  <= 1'b0;
      o_ratio <= '0;
      o_valid <= 1'b0;
    end else begin
      quo_r   <= quo_nxt;
      rem_r   <= rem_nxt;
      den_r   <= den_nxt;
      cnt_r   <= cnt_nxt;
      busy_r  <= busy_nxt;
      o_ratio <= ratio_nxt;
      o_valid <= valid_nxt;
    end
  end

endmodule
`default_nettype wire

// File: core/ocp_regs.svh
// Constants of the overcurrent pick-up comparator
`ifndef OCP_REGS_SVH
`define OCP_REGS_SVH

`define OCP_MAG_W          16
`define OCP_THR_W          13
`define OCP_TIME_W         19
`define OCP_RATIO_W        17
`define OCP_THR_DEFAULT    13'h0078
`define OCP_RESET_PCT      7'h61
`define OCP_FULL_PCT       7'h64
`define OCP_UPDATE_MS      5
`define OCP_PREFAULT_MS    20
`define OCP_PREFAULT_TAPS  (`OCP_PREFAULT_MS / `OCP_UPDATE_MS)
`define OCP_HIST_DEPTH     (2 * `OCP_PREFAULT_TAPS)
`define OCP_TIME_MAX       19'h57E40
`define OCP_RATIO_MAX      17'h1E848
`define OCP_PERM_ALLOWED   2'h2
`define OCP_PERM_DISABLED  2'h1

`endif

// File: verif/ocp_front_end.sv
// Measurement front end model: periodic magnitudes and raw samples
`timescale 1ns/1ps
`default_nettype none

module ocp_front_end #(
  parameter int          PERIOD     = 50,
  parameter logic [15:0] TRUE_RMS_MODE_EXTRA = 16'h0010
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset_n,
  input  wire logic [15:0] i_lvl_a,
  input  wire logic [15:0] i_lvl_b,
  input  wire logic [15:0] i_lvl_c,
  output logic             o_meas_valid = 1'b0,
  output logic [15:0]      o_rms_a,
  output logic [15:0]      o_rms_b,
  output logic [15:0]      o_rms_c,
  output logic [15:0]      o_true_rms_mode_a,
  output logic [15:0]      o_true_rms_mode_b,
  output logic [15:0]      o_true_rms_mode_c,
  output logic             o_sample_valid,
  output logic [47:0]      o_samples
);
  int   cnt_r = 0;
  logic pos_r = 1'b0;

  // ----------------------------------------------
  // Update pacing
  // ----------------------------------------------
  // One update per period stands in for the 5 ms time base
  always @(negedge i_ref_clk) begin
    if (!i_reset_n) begin
      cnt_r        <= 0;
      pos_r        <= 1'b0;
      o_meas_valid <= 1'b0;
    end else begin
      cnt_r        <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      pos_r        <= !pos_r;
      o_meas_valid <= (cnt_r == PERIOD - 1);
    end
  end

  // ----------------------------------------------
  // Values
  // ----------------------------------------------
  // Six magnitudes, all valid together on the update pulse
  assign o_rms_a  = i_lvl_a;
  assign o_rms_b  = i_lvl_b;
  assign o_rms_c  = i_lvl_c;
  // Harmonic content makes the true value stand apart from plain RMS
  assign o_true_rms_mode_a = i_lvl_a + TRUE_RMS_MODE_EXTRA;
  assign o_true_rms_mode_b = i_lvl_b + TRUE_RMS_MODE_EXTRA;
  assign o_true_rms_mode_c = i_lvl_c + TRUE_RMS_MODE_EXTRA;
  // Square wave of amplitude lvl, so peak-to-peak is twice the level
  assign o_sample_valid = i_reset_n;
  assign o_samples = pos_r ? {i_lvl_c, i_lvl_b, i_lvl_a} :
                     {16'h0000 - i_lvl_c, 16'h0000 - i_lvl_b,
                      16'h0000 - i_lvl_a};
endmodule

`default_nettype wire

// File: verif/ocp_pickup_tb_top.sv
// Self-checking bench for the overcurrent pick-up comparator
`timescale 1ns/1ps
`default_nettype none

module ocp_pickup_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] lvl_a = 16'h0000, lvl_b = 16'h0000, lvl_c = 16'h0000;
  logic        mv, sv;
  logic [15:0] ra, rb, rc, ta, tb, tc, mag, pf;
  logic [47:0] smp;
  logic [1:0]  sel = 2'h1, perm = 2'h1, sc;
  logic [12:0] thr = 13'h0000, thr_o;
  logic        wr_l = 1'b0, wr_r = 1'b0, blk = 1'b0, fen = 1'b0;
  logic        inv = 1'b0, st, tr, bl, rv;
  logic [4:0]  fcode = 5'h00;
  logic [18:0] dly = 19'h00064, idmt = 19'h00000, et, rt;
  logic [3:0]  pc;
  logic [16:0] ratio;
  logic [15:0] sel_exp [4] = '{16'h0064, 16'h0064, 16'h0074, 16'h00C8};
  logic [2:0]  msk [6] = '{3'h1, 3'h4, 3'h3, 3'h6, 3'h5, 3'h7};
  logic [3:0]  pexp [6] = '{4'h1, 4'h3, 4'h7, 4'h8, 4'h9, 4'hA};
  int          n_errors = 0, compares = 0, cyc = 0;

  ocp_front_end fe (.i_ref_clk(clk), .i_reset_n(rst_n), .i_lvl_a(lvl_a),
    .i_lvl_b(lvl_b), .i_lvl_c(lvl_c), .o_meas_valid(mv), .o_rms_a(ra),
    .o_rms_b(rb), .o_rms_c(rc), .o_true_rms_mode_a(ta), .o_true_rms_mode_b(tb),
    .o_true_rms_mode_c(tc), .o_sample_valid(sv), .o_samples(smp));

  ocp_pickup uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_meas_valid(mv),
    .i_phase_a_rms(ra), .i_phase_b_rms(rb), .i_phase_c_rms(rc),
    .i_phase_a_true_rms(ta), .i_phase_b_true_rms(tb),
    .i_phase_c_true_rms(tc), .i_sample_valid(sv), .i_samples(smp),
    .i_mag_select(sel), .i_thr_value(thr), .i_thr_wr_local(wr_l),
    .i_thr_wr_remote(wr_r), .i_remote_perm(perm), .i_block(blk),
    .i_force_en(fen), .i_force_code(fcode), .i_inverse_mode(inv),
    .i_op_delay(dly), .i_idmt_time(idmt), .o_start(st), .o_trip(tr),
    .o_blocked(bl), .o_stage_code(sc), .o_phase_code(pc),
    .o_threshold(thr_o), .o_measured_magnitude(mag), .o_prefault(pf),
    .o_expected_time(et), .o_remaining_time(rt), .o_ratio(ratio),
    .o_ratio_valid(rv));

  // ----------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------
  always #5 clk = ~clk;

  // About 47 updates of 50 cycles plus forcing fit well inside
  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------------
  // Tasks
  // ----------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Outputs stand until the next update, so two cycles later is safe
  task automatic nxt();
    @(posedge clk iff mv === 1'b1);
    repeat (2) @(negedge clk);
  endtask

  task automatic wthr(input logic [12:0] v, input logic rem);
    thr = v;
    wr_l = !rem;
    wr_r = rem;
    @(negedge clk);
    wr_l = 1'b0;
    wr_r = 1'b0;
    @(negedge clk);
  endtask

  task automatic close_out();
    $display("Checks made: %0d, mismatches: %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------
  // Tests
  // ----------------------------------------------
  initial begin
    repeat (8) @(negedge clk);
    chk(32'(thr_o), 32'h78);
    chk(32'({st, tr, bl, sc, pc}), 32'h0);
    rst_n = 1'b1;
    $display("test reset done");
    // Threshold out of reach while the selector is swept
    wthr(13'h1FFF, 1'b0);
    lvl_a = 16'h0064;
    for (int s = 0; s < 4; s++) begin
      sel = 2'(s);
      nxt();
      nxt();
      chk(32'(mag), 32'(sel_exp[s]));
    end
    sel = 2'h1;
    $display("test selector done");
    wthr(13'h0064, 1'b1);
    chk(32'(thr_o), 32'h1FFF);
    perm = 2'h2;
    wthr(13'h0064, 1'b1);
    chk(32'(thr_o), 32'h64);
    perm = 2'h1;
    wthr(13'h0078, 1'b0);
    chk(32'(thr_o), 32'h78);
    wthr(13'h0064, 1'b0);
    $display("test threshold done");
    lvl_a = 16'h0032;
    repeat (9) nxt();
    lvl_b = 16'h0065;
    nxt();
    chk(32'({st, sc, pc}), 32'h52);
    chk(32'(pf), 32'h32);
    chk(32'(et), 32'(dly));
    chk(32'(rt), 32'(dly));
    for (int i = 0; i < 40 && rv !== 1'b1; i++) @(negedge clk);
    chk(32'({rv, ratio}), 32'h20065);
    nxt();
    chk(32'(rt), 32'(dly) - 1);
    // Drop below release between updates: state must hold till next one
    lvl_b = 16'h0032;
    repeat (10) @(negedge clk);
    chk(32'(st), 32'h1);
    nxt();
    chk(32'({st, sc}), 32'h0);
    lvl_b = 16'h0065;
    nxt();
    lvl_b = 16'h0061;
    nxt();
    chk(32'(st), 32'h1);
    lvl_b = 16'h0060;
    nxt();
    chk(32'(st), 32'h0);
    lvl_b = 16'h0064;
    nxt();
    chk(32'(st), 32'h0);
    lvl_a = 16'h0000;
    lvl_b = 16'h0000;
    nxt();
    $display("test pick-up done");
    for (int i = 0; i < 6; i++) begin
      lvl_a = msk[i][0] ? 16'h0065 : 16'h0000;
      lvl_b = msk[i][1] ? 16'h0065 : 16'h0000;
      lvl_c = msk[i][2] ? 16'h0065 : 16'h0000;
      nxt();
      chk(32'(pc), 32'(pexp[i]));
      {lvl_a, lvl_b, lvl_c} = 48'h0;
      nxt();
    end
    $display("test phases done");
    dly = 19'h00002;
    lvl_a = 16'h0065;
    for (int i = 0; i < 6 && tr !== 1'b1; i++) nxt();
    chk(32'({tr, sc, pc}), 32'h64);
    inv = 1'b1;
    idmt = 19'h00007;
    nxt();
    chk(32'(et), 32'h7);
    lvl_a = 16'h0000;
    inv = 1'b0;
    dly = 19'h00064;
    nxt();
    $display("test trip done");
    blk = 1'b1;
    lvl_a = 16'h0065;
    nxt();
    chk(32'({bl, st, sc}), 32'hB);
    lvl_a = 16'h0000;
    blk = 1'b0;
    nxt();
    chk(32'(sc), 32'h0);
    // Block arriving while already started ends the start
    lvl_a = 16'h0065;
    nxt();
    chk(32'(st), 32'h1);
    blk = 1'b1;
    nxt();
    chk(32'({bl, st, sc}), 32'hB);
    lvl_a = 16'h0000;
    blk = 1'b0;
    nxt();
    chk(32'(sc), 32'h0);
    $display("test block done");
    fen = 1'b1;
    for (int k = 0; k < 18; k++) begin
      fcode = 5'(k);
      repeat (2) @(negedge clk);
      chk(32'(sc), 32'((k < 4) ? k :
          ((k < 7 || (k > 9 && k < 14)) ? 1 : 2)));
      chk(32'(pc), 32'((k < 4) ? 0 : k - 3));
    end
    fen = 1'b0;
    $display("test forcing done");
    close_out();
  end
endmodule

`default_nettype wire
